// >>> design/dms_pkg.sv
package dms_pkg;
	// Register byte addresses
	localparam logic [7:0] A_CTRL  = 8'h00;
	localparam logic [7:0] A_STAT  = 8'h04;
	localparam logic [7:0] A_SEL   = 8'h08;
	localparam logic [7:0] A_CFG0  = 8'h0c;
	localparam logic [7:0] A_CFG1  = 8'h10;
	localparam logic [7:0] A_CFG2  = 8'h14;
	localparam logic [7:0] A_CFG3  = 8'h18;
	localparam logic [7:0] A_CFG4  = 8'h1c;
	localparam logic [7:0] A_MADDR = 8'h20;
	localparam logic [7:0] A_MDATA = 8'h24;

	// Field positions
	localparam int F0_EN    = 0;
	localparam int F0_TYPE  = 1;
	localparam int F0_NODE  = 3;
	localparam int F0_FBOFF = 5;
	localparam int F0_SUBCLR = 7;
	localparam int F0_MODE  = 8;
	localparam int F0_SWAP  = 10;
	localparam int F0_CRC   = 12;
	localparam int F0_RTEN  = 13;
	localparam int F0_ADDR  = 14;
	localparam int F1_RETRY = 0;
	localparam int F1_TMO   = 8;
	localparam int F2_UPD   = 0;
	localparam int F2_SIZE  = 16;
	localparam int F2_LEN   = 24;
	localparam int F3_OFF   = 0;
	localparam int F3_RTRIG = 16;
	localparam int F4_STRIG = 0;
	localparam int C_RUN    = 0;
	localparam int C_FBON   = 1;

	// Reset values
	localparam logic [31:0] CFG0_RST = 32'h0000_1080;
	localparam logic [31:0] CFG1_RST = 32'h0000_6403;
	localparam logic [31:0] CFG2_RST = 32'h0202_0064;
	localparam logic [31:0] CFG3_RST = 32'h05ff_0000;
	localparam logic [31:0] CFG4_RST = 32'h0000_05ff;

	// Timing
	localparam int CLK_NS          = 40;
	localparam int TICK_MS         = 10;
	localparam int TICK_CYCLES_DEF = TICK_MS * 1000000 / CLK_NS;

	// Limits
	localparam int          NSVC_MAX   = 50;
	localparam logic [7:0]  DIAG_MAX_A = 8'h1a;
	localparam logic [7:0]  DIAG_MAX_B = 8'h1c;
	localparam logic [10:0] TRIG_LO    = 11'h200;

	// Command codes, values arbitrary
	localparam logic [7:0] CMD_ECHO   = 8'h10;
	localparam logic [7:0] CMD_DIAG   = 8'h11;
	localparam logic [7:0] CMD_RD_TYP = 8'h12;
	localparam logic [7:0] CMD_RD_LOG = 8'h13;
	localparam logic [7:0] CMD_WR_TYP = 8'h14;
	localparam logic [7:0] CMD_WR_LOG = 8'h15;
	localparam logic [7:0] ECHO_SEED  = 8'ha5;

	localparam logic [1:0] FILL_LIVE   = 2'b00;
	localparam logic [1:0] FILL_CLEAR  = 2'b01;
	localparam logic [1:0] FILL_FREEZE = 2'b10;

	typedef enum logic [1:0] {
		DMS_INTEG = 2'b00,
		DMS_DIAG  = 2'b01,
		DMS_READ  = 2'b10,
		DMS_WRITE = 2'b11
	} dms_svc_t;

	typedef enum logic [1:0] {
		DMS_NODE_A = 2'b00,
		DMS_NODE_B = 2'b01,
		DMS_NODE_C = 2'b10
	} dms_node_t;

	typedef enum logic [1:0] {
		DMS_CYCLIC = 2'b00,
		DMS_CHANGE = 2'b01,
		DMS_SINGLE = 2'b10,
		DMS_TRIG   = 2'b11
	} dms_mode_t;

	typedef enum logic [1:0] {
		DMS_FB_CLEAR  = 2'b00,
		DMS_FB_FREEZE = 2'b01,
		DMS_FB_NOSCAN = 2'b10
	} dms_fboff_t;

	typedef enum logic [1:0] {
		DMS_SW_NONE  = 2'b00,
		DMS_SW_WORD  = 2'b01,
		DMS_SW_DWORD = 2'b10
	} dms_swap_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ISSUE = 3'b001,
		ST_WAIT  = 3'b010,
		ST_CLEAR = 3'b011,
		ST_DONE  = 3'b100
	} dms_state_t;
endpackage : dms_pkg

// >>> design/dms_scheduler.sv
// Contract
// - At most fifty service instances in total
// - Four service types: integrity, diagnostics, read, write
// - Command chosen from service and node type
// - Fieldbus offline: clear, freeze or stop scanning
// - Subnetwork offline: clear or freeze reported data
// - Update mode: cyclic, change, single, trigger
// - Resend up to retry count, then disconnect
// - Wait timeout in 10 ms units before resend
// - Minimum update time between two executions
// - Timing fields count 10 ms units
// - Request trigger byte location starts updates
// - Response trigger byte enable, default off
// - Response trigger address from 0x200 upward only
// - Integrity check: slave echoes test telegram
// - Diagnostic size even, whole elements only
// - Diagnostic size limit depends on node type
// - Received bytes stored with selectable swap
// - Copy data length bytes, never above size
// - Received data placed at configured offset
// - Per node checksum: block check or CRC
//
// Design decisions made here: the address map and the APB register port.
module dms_scheduler
	import dms_pkg::*;
#(
	parameter int NSVC        = NSVC_MAX,
	parameter int AW          = 11,
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata_q,
	output logic             pready_q,
	output logic             pslverr_q,
	output logic             qry_valid_q,
	input  wire logic        qry_ready,
	output logic [7:0]       qry_cmd_q,
	output logic [7:0]       qry_node_q,
	output logic [7:0]       qry_size_q,
	output logic [5:0]       qry_svc_q,
	output logic             qry_crc_q,
	output logic [1:0]       qry_fill_q,
	input  wire logic        rsp_valid,
	input  wire logic [7:0]  rsp_byte,
	input  wire logic        rsp_last,
	input  wire logic        rsp_ok,
	output logic             rsp_ready_q
);
	localparam int MEMB = 1 << AW;

	logic [31:0] cfg0_q [NSVC];
	logic [31:0] cfg1_q [NSVC];
	logic [31:0] cfg2_q [NSVC];
	logic [31:0] cfg3_q [NSVC];
	logic [31:0] cfg4_q [NSVC];
	logic [7:0]  mem_q  [MEMB];
	logic [15:0] age_q  [NSVC];
	logic        done_q [NSVC];
	logic        dirty_q [NSVC];
	logic        disc_q [NSVC];
	logic [7:0]  ltrig_q [NSVC];

	logic [1:0]    ctrl_q;
	logic [5:0]    sel_q;
	logic [AW-1:0] maddr_q;
	dms_state_t    st_q, st_d;
	logic [5:0]    scan_q, cur_q;
	logic [7:0]    tries_q, idx_q;
	logic [15:0]   tmo_q;
	logic          echo_ok_q, mem_free_q;
	logic [31:0]   tick_cnt_q;
	logic          tick_q;

	// Query is judged against its whole expected reply, so a slave speaking out of turn
	// is simply not listened to outside the wait state.
	function automatic logic [7:0] cmd_sel(input logic [1:0] t, input logic [1:0] n);
		logic typed;
		typed = (n == DMS_NODE_A);
		case (t)
			DMS_INTEG: cmd_sel = CMD_ECHO;
			DMS_DIAG:  cmd_sel = CMD_DIAG;
			DMS_READ:  cmd_sel = typed ? CMD_RD_TYP : CMD_RD_LOG;
			default:   cmd_sel = typed ? CMD_WR_TYP : CMD_WR_LOG;
		endcase
	endfunction : cmd_sel

	function automatic logic cfg_ok(input logic [31:0] c0, input logic [31:0] c2, input logic [31:0] c4);
		logic [7:0] sz;
		logic [7:0] lim;
		logic       ok;
		sz  = c2[F2_SIZE +: 8];
		lim = (c0[F0_NODE +: 2] == DMS_NODE_B) ? DIAG_MAX_B : DIAG_MAX_A;
		ok  = (c0[F0_NODE +: 2] != 2'b11) && (c0[F0_SWAP +: 2] != 2'b11) && (c0[F0_FBOFF +: 2] != 2'b11);
		ok  = ok && (c2[F2_LEN +: 8] <= sz);
		if (c0[F0_TYPE +: 2] == DMS_DIAG)
			ok = ok && !sz[0] && (sz != 8'h00) && (sz <= lim);
		if (c0[F0_RTEN])
			ok = ok && (c4[F4_STRIG +: AW] >= TRIG_LO);
		cfg_ok = ok;
	endfunction : cfg_ok

	// APB decode
	wire         setup    = psel & ~penable;
	wire         access   = psel & penable & pready_q;
	wire         wr_go    = access & pwrite & ~pslverr_q;
	wire         is_cfg   = (paddr == A_CFG0) | (paddr == A_CFG1) | (paddr == A_CFG2) |
	                        (paddr == A_CFG3) | (paddr == A_CFG4);
	wire         mapped   = is_cfg | (paddr == A_CTRL) | (paddr == A_STAT) | (paddr == A_SEL) |
	                        (paddr == A_MADDR) | (paddr == A_MDATA);
	wire [31:0]  nc0      = (paddr == A_CFG0) ? pwdata : cfg0_q[sel_q];
	wire [31:0]  nc2      = (paddr == A_CFG2) ? pwdata : cfg2_q[sel_q];
	wire [31:0]  nc4      = (paddr == A_CFG4) ? pwdata : cfg4_q[sel_q];
	wire         sel_bad  = (paddr == A_SEL) & (pwdata >= 32'(NSVC));
	wire         wr_bad   = (paddr == A_STAT) | sel_bad | (is_cfg & ~cfg_ok(nc0, nc2, nc4));
	wire         err_d    = ~mapped | (pwrite & wr_bad);
	wire [31:0]  stat_w   = {8'h00, tries_q, 4'h0, ctrl_q[C_FBON], done_q[sel_q], disc_q[sel_q],
	                        (st_q != ST_IDLE), 2'b00, cur_q};
	logic [31:0] rd_w;
	always_comb begin
		case (paddr)
			A_CTRL:  rd_w = {30'h0, ctrl_q};
			A_STAT:  rd_w = stat_w;
			A_SEL:   rd_w = {26'h0, sel_q};
			A_CFG0:  rd_w = cfg0_q[sel_q];
			A_CFG1:  rd_w = cfg1_q[sel_q];
			A_CFG2:  rd_w = cfg2_q[sel_q];
			A_CFG3:  rd_w = cfg3_q[sel_q];
			A_CFG4:  rd_w = cfg4_q[sel_q];
			A_MADDR: rd_w = {{(32-AW){1'b0}}, maddr_q};
			A_MDATA: rd_w = {24'h0, mem_q[maddr_q]};
			default: rd_w = 32'h0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup ? err_d : 1'b0;
			prdata_q  <= (setup && !pwrite) ? rd_w : 32'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q  <= 2'b00;
			sel_q   <= 6'h0;
			maddr_q <= '0;
			for (int i = 0; i < NSVC; i++) begin
				cfg0_q[i] <= CFG0_RST;
				cfg1_q[i] <= CFG1_RST;
				cfg2_q[i] <= CFG2_RST;
				cfg3_q[i] <= CFG3_RST;
				cfg4_q[i] <= CFG4_RST;
			end
		end else if (wr_go) begin
			case (paddr)
				A_CTRL:  ctrl_q <= pwdata[1:0];
				A_SEL:   sel_q <= pwdata[5:0];
				A_CFG0:  cfg0_q[sel_q] <= pwdata;
				A_CFG1:  cfg1_q[sel_q] <= pwdata;
				A_CFG2:  cfg2_q[sel_q] <= pwdata;
				A_CFG3:  cfg3_q[sel_q] <= pwdata;
				A_CFG4:  cfg4_q[sel_q] <= pwdata;
				A_MADDR: maddr_q <= pwdata[AW-1:0];
				default: ;
			endcase
		end
	end

	// Service currently scanned
	wire [31:0]   s0     = cfg0_q[scan_q];
	wire [31:0]   s2     = cfg2_q[scan_q];
	wire [AW-1:0] s_trig = cfg3_q[scan_q][F3_RTRIG +: AW];
	wire          fb_on  = ctrl_q[C_FBON];
	wire          s_nosc = ~fb_on & (s0[F0_FBOFF +: 2] == DMS_FB_NOSCAN);
	wire          s_due  = age_q[scan_q] >= s2[F2_UPD +: 16];
	logic         s_mode;
	always_comb begin
		case (s0[F0_MODE +: 2])
			DMS_CYCLIC: s_mode = 1'b1;
			DMS_CHANGE: s_mode = dirty_q[scan_q];
			DMS_SINGLE: s_mode = ~done_q[scan_q];
			DMS_TRIG:   s_mode = mem_q[s_trig] != ltrig_q[scan_q];
			default:    s_mode = 1'b0;
		endcase
	end
	wire          s_elig = ctrl_q[C_RUN] & s0[F0_EN] & ~s_nosc & s_due & s_mode;

	// Service in flight
	wire [31:0]   c0     = cfg0_q[cur_q];
	wire [31:0]   c1     = cfg1_q[cur_q];
	wire [31:0]   c2     = cfg2_q[cur_q];
	wire [AW-1:0] c_off  = cfg3_q[cur_q][F3_OFF +: AW];
	wire [AW-1:0] c_str  = cfg4_q[cur_q][F4_STRIG +: AW];
	wire [1:0]    c_type = c0[F0_TYPE +: 2];
	wire [7:0]    c_len  = c2[F2_LEN +: 8];
	wire          c_rd   = (c_type == DMS_DIAG) | (c_type == DMS_READ);
	wire [7:0]    sw_msk = (c0[F0_SWAP +: 2] == DMS_SW_DWORD) ? 8'h03 :
	                       (c0[F0_SWAP +: 2] == DMS_SW_WORD) ? 8'h01 : 8'h00;
	wire [7:0]    sw_idx = idx_q ^ sw_msk;
	wire          rx_tk  = (st_q == ST_WAIT) & rsp_valid & rsp_ready_q;
	wire          echo_m = rsp_byte == (ECHO_SEED ^ idx_q);
	wire          rx_good = rx_tk & rsp_last & rsp_ok & ((c_type != DMS_INTEG) | (echo_ok_q & echo_m));
	wire          tmo_hit = (st_q == ST_WAIT) & tick_q & (tmo_q >= c1[F1_TMO +: 16]);
	wire          retry  = tmo_hit & (tries_q < c1[F1_RETRY +: 8]);
	wire          lost   = tmo_hit & ~retry;
	wire          issued = qry_valid_q & qry_ready;
	wire          clr_end = (st_q == ST_CLEAR) & mem_free_q & (idx_q + 8'h01 >= c_len);

	// Query fields come from the slot that was found eligible. Leaving idle, cur_q
	// still lags the scan by one slot, so it cannot be used on that edge.
	// A resend from the wait state rebuilds the query from cur_q.
	wire [5:0]    q_idx  = (st_q == ST_IDLE) ? scan_q : cur_q;
	wire [31:0]   q0     = cfg0_q[q_idx];
	wire [31:0]   q2     = cfg2_q[q_idx];
	wire [1:0]    q_type = q0[F0_TYPE +: 2];
	wire [7:0]    q_len  = q2[F2_LEN +: 8];
	wire [7:0]    q_size = q2[F2_SIZE +: 8];
	// An integrity check sends data-length bytes as its test telegram

	// Single memory write port; APB traffic blocks the scheduler's own writes
	wire          rx_we  = rx_tk & c_rd & (sw_idx < c_len) & (idx_q < c_len);
	wire          clr_we = (st_q == ST_CLEAR) & mem_free_q & (c_len != 8'h00);
	wire          rt_we  = (st_q == ST_DONE) & mem_free_q & c0[F0_RTEN] & (c_str >= TRIG_LO);
	wire          apb_we = wr_go & (paddr == A_MDATA);
	wire          mem_we = apb_we | rx_we | clr_we | rt_we;
	wire [AW-1:0] mem_wa = apb_we ? maddr_q :
	                       rt_we ? c_str :
	                       rx_we ? c_off + AW'(sw_idx) : c_off + AW'(idx_q);
	wire [7:0]    mem_wd = apb_we ? pwdata[7:0] :
	                       rt_we ? mem_q[c_str] + 8'h01 :
	                       rx_we ? rsp_byte : 8'h00;

	always_ff @(posedge pclk) begin
		if (mem_we)
			mem_q[mem_wa] <= mem_wd;
	end

	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_IDLE:  st_d = s_elig ? ST_ISSUE : ST_IDLE;
			ST_ISSUE: st_d = issued ? ST_WAIT : ST_ISSUE;
			ST_WAIT: begin
				if (rx_good)
					st_d = ST_DONE;
				else if (retry)
					st_d = ST_ISSUE;
				else if (lost)
					st_d = (c_rd & c0[F0_SUBCLR]) ? ST_CLEAR : ST_IDLE;
			end
			ST_CLEAR: st_d = (clr_end || c_len == 8'h00) ? ST_IDLE : ST_CLEAR;
			ST_DONE:  st_d = mem_free_q ? ST_IDLE : ST_DONE;
			default:  st_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q       <= ST_IDLE;
			scan_q     <= 6'h0;
			cur_q      <= 6'h0;
			tries_q    <= 8'h0;
			idx_q      <= 8'h0;
			tmo_q      <= 16'h0;
			echo_ok_q  <= 1'b1;
			mem_free_q <= 1'b0;
			rsp_ready_q <= 1'b0;
			tick_cnt_q <= 32'h0;
			tick_q     <= 1'b0;
		end else begin
			st_q       <= st_d;
			mem_free_q <= ~psel;
			rsp_ready_q <= (st_d == ST_WAIT) & ~psel;
			tick_q     <= tick_cnt_q == 32'(TICK_CYCLES - 1);
			tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_cnt_q + 32'h1;
			if (st_q == ST_IDLE) begin
				cur_q   <= scan_q;
				scan_q  <= (s_elig || scan_q == 6'(NSVC - 1)) ? ((scan_q == 6'(NSVC - 1)) ? 6'h0 : scan_q + 6'h1)
				                                              : scan_q + 6'h1;
				tries_q <= 8'h0;
			end
			if (issued) begin
				tmo_q     <= 16'h0;
				idx_q     <= 8'h0;
				echo_ok_q <= 1'b1;
			end else if (st_q == ST_WAIT) begin
				if (tick_q)
					tmo_q <= tmo_q + 16'h1;
				if (rx_tk) begin
					idx_q     <= idx_q + 8'h1;
					echo_ok_q <= echo_ok_q & echo_m;
					// A bad reply leaves the wait for the timeout to resend
					if (rsp_last && !rx_good)
						idx_q <= 8'h0;
				end
				if (lost)
					idx_q <= 8'h0;
			end else if (st_q == ST_CLEAR && mem_free_q) begin
				idx_q <= idx_q + 8'h1;
			end
			if (retry)
				tries_q <= tries_q + 8'h1;
			else if (rx_good || lost)
				tries_q <= 8'h0;
		end
	end

	// Per-service history; age saturates so a long idle service is due at once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NSVC; i++) begin
				age_q[i]   <= 16'hffff;
				done_q[i]  <= 1'b0;
				dirty_q[i] <= 1'b0;
				disc_q[i]  <= 1'b0;
				ltrig_q[i] <= 8'h00;
			end
		end else begin
			for (int i = 0; i < NSVC; i++) begin
				if (tick_q && age_q[i] != 16'hffff)
					age_q[i] <= age_q[i] + 16'h1;
				if (apb_we && maddr_q >= cfg3_q[i][F3_OFF +: AW] &&
				    {1'b0, maddr_q} < ({1'b0, cfg3_q[i][F3_OFF +: AW]} + (AW+1)'(cfg2_q[i][F2_LEN +: 8])))
					dirty_q[i] <= 1'b1;
			end
			if (st_q == ST_IDLE && s_elig) begin
				age_q[scan_q]   <= 16'h0;
				dirty_q[scan_q] <= 1'b0;
				ltrig_q[scan_q] <= mem_q[s_trig];
			end
			if (rx_good) begin
				disc_q[cur_q] <= 1'b0;
				if (c0[F0_MODE +: 2] == DMS_SINGLE)
					done_q[cur_q] <= 1'b1;
			end
			if (lost)
				disc_q[cur_q] <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			qry_valid_q <= 1'b0;
			qry_cmd_q   <= 8'h0;
			qry_node_q  <= 8'h0;
			qry_size_q  <= 8'h0;
			qry_svc_q   <= 6'h0;
			qry_crc_q   <= 1'b1;
			qry_fill_q  <= FILL_LIVE;
		end else begin
			qry_valid_q <= (st_d == ST_ISSUE) & ~issued;
			if (st_d == ST_ISSUE && st_q != ST_ISSUE) begin
				qry_cmd_q  <= cmd_sel(q_type, q0[F0_NODE +: 2]);
				qry_node_q <= q0[F0_ADDR +: 8];
				qry_size_q <= (q_type == DMS_INTEG) ? q_len : q_size;
				qry_svc_q  <= q_idx;
				qry_crc_q  <= q0[F0_CRC];
				qry_fill_q <= fb_on ? FILL_LIVE :
				              (q0[F0_FBOFF +: 2] == DMS_FB_FREEZE) ? FILL_FREEZE : FILL_CLEAR;
			end
		end
	end
endmodule : dms_scheduler

// >>> verification/dms_scheduler_asserts.sv
module dms_scheduler_asserts
	import dms_pkg::*;
#(
	parameter int NSVC = NSVC_MAX
) (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready_q,
	input wire logic       qry_valid_q,
	input wire logic       qry_ready,
	input wire logic [7:0] qry_cmd_q,
	input wire logic [7:0] qry_node_q,
	input wire logic [7:0] qry_size_q,
	input wire logic [5:0] qry_svc_q,
	input wire logic       rsp_ready_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_accept;
		qry_valid_q && qry_ready;
	endsequence
	sequence s_stall;
		qry_valid_q && !qry_ready;
	endsequence
	a_pready_next: assert property (s_setup |=> pready_q)
		else $error("no ready after setup");
	a_pready_cause: assert property (pready_q |-> $past(psel && !penable))
		else $error("ready without setup");
	a_qry_hold: assert property (s_stall |=> qry_valid_q && $stable({qry_cmd_q, qry_node_q, qry_size_q, qry_svc_q}))
		else $error("query changed before accept");
	a_qry_drop: assert property (s_accept |=> !qry_valid_q [*2])
		else $error("query offered right after accept");
	a_rsp_quiet: assert property (rsp_ready_q |-> !qry_valid_q)
		else $error("reply accepted while query offered");
	a_rdy_psel: assert property (psel |=> !rsp_ready_q)
		else $error("reply accepted during bus access");
	a_cmd_legal: assert property (qry_valid_q |-> qry_cmd_q inside {[CMD_ECHO:CMD_WR_LOG]})
		else $error("unknown command code");
	a_diag_size: assert property (qry_valid_q && qry_cmd_q == CMD_DIAG |-> !qry_size_q[0] && qry_size_q inside {[2:28]})
		else $error("bad diagnostic size");
	a_svc_range: assert property (qry_valid_q |-> qry_svc_q < NSVC)
		else $error("service index out of range");
	a_echo_size: assert property (qry_valid_q && qry_cmd_q == CMD_ECHO |-> qry_size_q != 8'h00)
		else $error("empty test telegram");
endmodule : dms_scheduler_asserts

bind dms_scheduler dms_scheduler_asserts #(.NSVC(NSVC)) i_chk (.pclk, .presetn, .psel, .penable, .pready_q,
	.qry_valid_q, .qry_ready, .qry_cmd_q, .qry_node_q, .qry_size_q, .qry_svc_q, .rsp_ready_q);

// >>> verification/dms_slave_model.sv
module dms_slave_model
	import dms_pkg::*;
(
	input wire logic       pclk,
	input wire logic       qry_valid_q,
	input wire logic [7:0] qry_cmd_q,
	input wire logic [7:0] qry_size_q,
	input wire logic       rsp_ready_q,
	output logic           qry_ready,
	output logic           rsp_valid,
	output logic [7:0]     rsp_byte,
	output logic           rsp_last,
	output logic           rsp_ok
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       silent = 1'b0;
	int         slow = 0;
	int         n_qry = 0;
	int         cyc = 0;
	int         t_prev = 0;
	int         t_last = 0;
	logic [7:0] last_cmd = 8'h00;
	logic [7:0] size;
	logic [7:0] i;
	initial begin
		qry_ready = 1'b0;
		rsp_valid = 1'b0;
		rsp_byte = 8'h5a;
		rsp_last = 1'b0;
		rsp_ok = 1'b0;
	end
	always @(posedge pclk) cyc++;
	// Speaks only after taking a query
	always begin
		@(posedge pclk);
		if (qry_valid_q === 1'b1) begin
			repeat (slow) @(posedge pclk);
			qry_ready <= 1'b1;
			@(posedge pclk);
			qry_ready <= 1'b0;
			n_qry++;
			t_prev = t_last;
			t_last = cyc;
			last_cmd = qry_cmd_q;
			size = qry_size_q;
			if (!silent) begin
				for (i = 8'h00; i < size; i++) begin
					rsp_valid <= 1'b1;
					rsp_byte <= (last_cmd == CMD_ECHO) ? (ECHO_SEED ^ i) : (8'h30 + i);
					rsp_last <= (i == size - 8'h01);
					rsp_ok <= (i == size - 8'h01);
					do @(posedge pclk); while (rsp_ready_q !== 1'b1);
				end
				// Released line shows the inverse so a stale byte cannot pass
				rsp_valid <= 1'b0;
				rsp_byte <= ~rsp_byte;
				rsp_last <= 1'b0;
				rsp_ok <= 1'b0;
			end
		end
	end
endmodule : dms_slave_model

// >>> verification/test_df1_master_service_scheduler.sv
module test_df1_master_service_scheduler
	import dms_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata_q;
	logic        pready_q, pslverr_q, qry_valid_q, qry_ready, qry_crc_q;
	logic        rsp_valid, rsp_last, rsp_ok, rsp_ready_q;
	logic [7:0]  qry_cmd_q, qry_node_q, qry_size_q, rsp_byte;
	logic [5:0]  qry_svc_q;
	logic [1:0]  qry_fill_q;
	int          mismatches = 0;
	int          n_tests = 0;
	logic [7:0]  q_node;
	logic [5:0]  q_svc;
	logic [1:0]  q_fill;
	logic        q_crc;
	always #20 pclk = ~pclk;

	// Fields of the last query the partner accepted
	always @(posedge pclk) begin
		if (qry_valid_q === 1'b1 && qry_ready === 1'b1) begin
			q_node <= qry_node_q;
			q_svc  <= qry_svc_q;
			q_fill <= qry_fill_q;
			q_crc  <= qry_crc_q;
		end
	end

	// Short tick keeps timeouts to tens of cycles
	dms_scheduler #(.TICK_CYCLES(20)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata_q, .pready_q, .pslverr_q, .qry_valid_q, .qry_ready, .qry_cmd_q, .qry_node_q, .qry_size_q,
		.qry_svc_q, .qry_crc_q, .qry_fill_q, .rsp_valid, .rsp_byte, .rsp_last, .rsp_ok, .rsp_ready_q);
	dms_slave_model i_slave (.pclk, .qry_valid_q, .qry_cmd_q, .qry_size_q, .rsp_ready_q, .qry_ready,
		.rsp_valid, .rsp_byte, .rsp_last, .rsp_ok);

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready_q !== 1'b1);
		r = prdata_q;
		e = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic ee);
		logic [31:0] r;
		logic        e;
		apb(w, a, d, r, e);
		chk({31'h0, e}, {31'h0, ee}, "slave error");
		if (!w && !ee) chk(r, d, "read data");
	endtask : xfer

	task automatic stat(input int b, output logic [31:0] r);
		logic e;
		int   k;
		for (k = 0; k < 400; k++) begin
			apb(1'b0, A_STAT, 32'h0, r, e);
			if (r[b] === 1'b1) break;
		end
		chk({31'h0, r[b]}, 32'h1, "status flag");
	endtask : stat

	task automatic t_regs();
		xfer(0, A_CFG0, CFG0_RST, 0);
		xfer(0, A_CFG1, 32'h0000_6403, 0);
		xfer(0, A_CFG2, 32'h0202_0064, 0);
		xfer(0, A_CFG3, 32'h05ff_0000, 0);
		xfer(0, A_CFG4, 32'h0000_05ff, 0);
		xfer(0, 8'h28, 32'h0, 1);
		xfer(1, A_STAT, 32'h1, 1);
	endtask : t_regs

	task automatic t_limits();
		xfer(1, A_SEL, 32'd49, 0);
		xfer(1, A_SEL, 32'd50, 1);
		xfer(1, A_SEL, 32'd3, 0);
		xfer(1, A_CFG0, 32'h0000_1082, 0);
		xfer(1, A_CFG2, 32'h0203_0064, 1);
		xfer(1, A_CFG2, 32'h021c_0064, 1);
		xfer(1, A_CFG0, 32'h0000_308a, 0);
		xfer(1, A_CFG2, 32'h021c_0064, 0);
		xfer(1, A_CFG4, 32'h0000_01ff, 1);
		xfer(1, A_CFG4, 32'h0000_0200, 0);
	endtask : t_limits

	task automatic t_integ();
		logic [31:0] r;
		xfer(1, A_CTRL, 32'h3, 0);
		xfer(1, A_SEL, 32'd0, 0);
		xfer(1, A_CFG0, 32'h0000_1281, 0);
		stat(10, r);
		chk({24'h0, r[23:16]}, 32'h0, "retry count");
		chk({24'h0, i_slave.last_cmd}, {24'h0, CMD_ECHO}, "echo command");
	endtask : t_integ

	task automatic t_read();
		logic [31:0] r;
		int          i;
		i_slave.slow = 3;
		xfer(1, A_SEL, 32'd1, 0);
		xfer(1, A_CFG2, 32'h0404_0064, 0);
		xfer(1, A_CFG3, 32'h05ff_0010, 0);
		xfer(1, A_CFG0, 32'h0000_1685, 0);
		stat(10, r);
		chk({24'h0, i_slave.last_cmd}, {24'h0, CMD_RD_TYP}, "read command");
		for (i = 0; i < 4; i++) begin
			xfer(1, A_MADDR, 32'h10 + i, 0);
			xfer(0, A_MDATA, 32'h30 + (i ^ 1), 0);
		end
	endtask : t_read

	task automatic t_retry();
		logic [31:0] r;
		int          n0;
		int          k;
		i_slave.slow = 0;
		i_slave.silent = 1'b1;
		n0 = i_slave.n_qry;
		xfer(1, A_SEL, 32'd2, 0);
		xfer(1, A_CFG1, 32'h0000_0201, 0);
		xfer(1, A_CFG0, 32'h0000_1285, 0);
		stat(9, r);
		chk(32'(i_slave.n_qry - n0), 32'd2, "query count");
		chk({31'h0, (i_slave.t_last - i_slave.t_prev) >= 40}, 32'h1, "resend gap");
		chk({26'h0, q_svc}, 32'd2, "query service");
		chk({30'h0, q_fill}, {30'h0, FILL_LIVE}, "fill mode");
		chk({31'h0, q_crc}, 32'h1, "checksum kind");
		for (k = 0; k < 2; k++) begin
			xfer(1, A_MADDR, k, 0);
			xfer(0, A_MDATA, 32'h0, 0);
		end
	endtask : t_retry

	task automatic t_offline();
		logic [31:0] r;
		int          n0;
		i_slave.silent = 1'b0;
		xfer(1, A_CTRL, 32'h1, 0);
		xfer(1, A_SEL, 32'd4, 0);
		xfer(1, A_CFG0, 32'h0004_8221, 0);
		stat(10, r);
		chk({30'h0, q_fill}, {30'h0, FILL_FREEZE}, "fill mode");
		chk({31'h0, q_crc}, 32'h0, "checksum kind");
		chk({24'h0, q_node}, 32'h12, "node address");
		chk({26'h0, q_svc}, 32'd4, "query service");
		n0 = i_slave.n_qry;
		xfer(1, A_SEL, 32'd5, 0);
		xfer(1, A_CFG0, 32'h0000_1041, 0);
		repeat (100) @(posedge pclk);
		chk(32'(i_slave.n_qry - n0), 32'd0, "queries while not scanning");
		xfer(1, A_CTRL, 32'h3, 0);
		repeat (100) @(posedge pclk);
		chk(32'(i_slave.n_qry - n0), 32'd1, "queries after fieldbus back");
		xfer(1, A_CFG0, 32'h0000_1040, 0);
	endtask : t_offline

	task automatic t_modes();
		int n0;
		n0 = i_slave.n_qry;
		xfer(1, A_MADDR, 32'h80, 0);
		xfer(1, A_MDATA, 32'h0, 0);
		xfer(1, A_SEL, 32'd6, 0);
		xfer(1, A_CFG3, 32'h05ff_0040, 0);
		xfer(1, A_CFG0, 32'h0000_1101, 0);
		xfer(1, A_SEL, 32'd7, 0);
		xfer(1, A_CFG3, 32'h0080_0000, 0);
		xfer(1, A_CFG0, 32'h0000_1301, 0);
		repeat (100) @(posedge pclk);
		chk(32'(i_slave.n_qry - n0), 32'd0, "queries without cause");
		xfer(1, A_MADDR, 32'h41, 0);
		xfer(1, A_MDATA, 32'h77, 0);
		repeat (100) @(posedge pclk);
		chk(32'(i_slave.n_qry - n0), 32'd1, "queries after data change");
		xfer(1, A_MADDR, 32'h80, 0);
		xfer(1, A_MDATA, 32'h01, 0);
		repeat (100) @(posedge pclk);
		chk(32'(i_slave.n_qry - n0), 32'd2, "queries after trigger change");
	endtask : t_modes

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_limits();
		t_integ();
		t_read();
		t_retry();
		t_offline();
		t_modes();
		close_out();
	end

	// Longest path is a few thousand cycles of polling
	initial begin
		repeat (40000) @(posedge pclk);
		mismatches++;
		close_out();
	end
endmodule : test_df1_master_service_scheduler
